// ---- inc/mps_pkg.sv ----
package mps_pkg;

    // clock and timing
    localparam int unsigned CLK_PERIOD_NS    = 20;
    localparam int unsigned MGMT_INIT_NS     = 1000;
    localparam int unsigned MGMT_INIT_CYCLES = (MGMT_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PWRUP_NS         = 2000;
    localparam int unsigned PWRUP_CYCLES     = (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DP_INIT_NS       = 1000;
    localparam int unsigned DP_INIT_CYCLES   = (DP_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W          = 12;

    localparam int unsigned LANES = 8;

    // register byte offsets
    localparam logic [7:0] OFS_STATUS     = 8'h00;
    localparam logic [7:0] OFS_CTRL       = 8'h04;
    localparam logic [7:0] OFS_DEINIT     = 8'h08;
    localparam logic [7:0] OFS_TXDIS      = 8'h0c;
    localparam logic [7:0] OFS_SQUELCH    = 8'h10;
    localparam logic [7:0] OFS_FLAGS      = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;
    localparam logic [7:0] OFS_ACTIVE_CFG = 8'h1c;
    localparam logic [7:0] OFS_STAGED_CFG = 8'h20;

    // field positions
    localparam int unsigned CTRL_SW_LP_BIT     = 0;
    localparam int unsigned CTRL_HW_PERMIT_BIT = 1;
    localparam int unsigned STAT_STATE_LSB     = 0;
    localparam int unsigned STAT_LP_EFF_BIT    = 2;
    localparam int unsigned STAT_LP_PIN_BIT    = 3;
    localparam int unsigned STAT_MODULE_SELECT_PIN_BIT    = 4;
    localparam int unsigned STAT_LANE_LSB      = 16;
    localparam int unsigned FLAG_MOD_BIT       = 0;
    localparam int unsigned FLAG_DP_LSB        = 1;
    localparam int unsigned FLAG_W             = 1 + LANES;

    // reset and power-on defaults
    localparam logic       SW_LP_RST     = 1'b0;
    localparam logic       HW_PERMIT_RST = 1'b1;
    localparam logic [7:0] DEINIT_RST    = 8'h00;
    localparam logic [7:0] TXDIS_RST     = 8'h00;
    localparam logic [7:0] SQUELCH_RST   = 8'h00;
    localparam logic [7:0] DP_CFG_RST    = 8'h01;
    localparam logic [FLAG_W-1:0] IRQ_MASK_RST = '0;

    typedef enum logic [1:0] {
        mgmt_init_state,
        low_power_state,
        power_up_state,
        ready_state
    } mps_mod_state_t;

    typedef enum logic [1:0] {
        datapath_deactivated_state,
        dp_init_state,
        datapath_initialized_state,
        dp_activated_state
    } mps_dp_state_t;

    typedef struct packed {
        logic       sw_lowpower_request;
        logic       hw_lowpower_permit;
        logic [7:0] datapath_deinit_mask;
        logic [7:0] tx_output_disable_mask;
        logic [7:0] tx_squelch_force_mask;
    } mps_ctrl_t;

    localparam mps_ctrl_t CTRL_RST = '{SW_LP_RST, HW_PERMIT_RST, DEINIT_RST, TXDIS_RST, SQUELCH_RST};

endpackage

// ---- core/mps_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module mps_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // level in and out
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    // meta_q is read by sync_o alone
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule // mps_sync
`default_nettype wire

// ---- core/mps_dp_lane.sv ----
`timescale 1ns/1ps
`default_nettype none
module mps_dp_lane #(
    parameter int unsigned INIT_CYCLES = mps_pkg::DP_INIT_CYCLES
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // steering
    input  wire logic                  module_ready,
    input  wire logic                  deinit_bit,
    input  wire logic                  tx_disable_bit,
    // lane state
    output mps_pkg::mps_dp_state_t     state_o,
    output logic                       changed_o,
    output logic                       tx_enable_o
);
    import mps_pkg::*;

    logic [TIMER_W-1:0] timer_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_o   <= datapath_deactivated_state;
            timer_q   <= '0;
            changed_o <= 1'b0;
        end else begin
            changed_o <= 1'b0;
            if (!module_ready || deinit_bit) begin
                // a set deinit bit alone deactivates the lane; ready_state need not be left
                if (state_o != datapath_deactivated_state)
                    changed_o <= 1'b1;
                state_o <= datapath_deactivated_state;
                timer_q <= '0;
            end else begin
                case (state_o)
                    datapath_deactivated_state: begin
                        state_o <= dp_init_state;
                        timer_q <= '0;
                    end
                    dp_init_state: begin
                        timer_q <= timer_q + 1'b1;
                        if (timer_q == TIMER_W'(INIT_CYCLES - 1)) begin
                            state_o   <= datapath_initialized_state;
                            changed_o <= 1'b1;
                        end
                    end
                    datapath_initialized_state: begin
                        // a set disable bit holds the lane here
                        if (!tx_disable_bit) begin
                            state_o   <= dp_activated_state;
                            changed_o <= 1'b1;
                        end
                    end
                    dp_activated_state: begin
                        if (tx_disable_bit) begin
                            state_o   <= datapath_initialized_state;
                            changed_o <= 1'b1;
                        end
                    end
                    default: state_o <= datapath_deactivated_state;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            tx_enable_o <= 1'b0;
        else
            tx_enable_o <= module_ready && !deinit_bit && !tx_disable_bit
                           && (state_o == dp_activated_state);
    end
endmodule // mps_dp_lane
`default_nettype wire

// ---- core/mps_top.sv ----
// Contract
// - after power-up the management registers load sw request 0, hw permit 1 and all three lane masks 00h.
// - while in management init the default lane configuration is written to the active and staged sets.
// - entering low power sets the module state changed flag, which raises the interrupt, lanes stay deactivated.
// - a read of the flag register clears the flags it returned and so drops the interrupt.
// - a deinit mask bit that is set keeps its lane from starting initialization in ready state.
// - a tx disable mask bit that is set keeps an initialized lane from being activated.
// - clearing the hw permit in low power, with the sw request 0, starts the climb to high power and ready state.
// - once the effective low power signal is false the module leaves low power for power up.
// - in power up the module raises its high power supply while all lanes stay deactivated.
// - entering ready state sets the module state changed flag again with lanes still deactivated.
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mps_top #(
    parameter int unsigned MGMT_CYCLES  = mps_pkg::MGMT_INIT_CYCLES,
    parameter int unsigned PWRUP_CYC    = mps_pkg::PWRUP_CYCLES,
    parameter int unsigned DP_INIT_CYC  = mps_pkg::DP_INIT_CYCLES,
    parameter logic [7:0]  DP_CFG_DEF   = mps_pkg::DP_CFG_RST
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    // wishbone classic slave
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [7:0]                    wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    // module pins
    input  wire logic                          lowpower_request_pin,
    input  wire logic                          module_select_pin,
    output logic                               irq_o,
    // power and lane control
    output mps_pkg::mps_mod_state_t            module_state_o,
    output logic                               high_power_en_o,
    output logic      [mps_pkg::LANES-1:0]     tx_enable_o,
    output logic      [mps_pkg::LANES-1:0]     tx_squelch_o
);
    import mps_pkg::*;

    mps_ctrl_t           ctrl_q;
    logic [7:0]          active_cfg_q;
    logic [7:0]          staged_cfg_q;
    logic [FLAG_W-1:0]   flags_q;
    logic [FLAG_W-1:0]   irq_mask_q;
    logic [FLAG_W-1:0]   flag_set;
    logic [FLAG_W-1:0]   rd_clear;
    logic [TIMER_W-1:0]  timer_q;
    logic                lp_pin_s;
    logic                module_select_pin_s;
    logic                lowpower_effective;
    logic                mod_entry_pulse;
    mps_mod_state_t      state_d;
    mps_dp_state_t       lane_state [LANES];
    logic [LANES-1:0]    lane_changed;
    logic [LANES-1:0]    lane_tx_en;
    logic [2*LANES-1:0]  lane_state_bits;

    // bus decode
    logic                req;
    logic                wr_ev;
    logic                rd_ev;
    logic [31:0]         wmask;
    logic [31:0]         rd_word;

    // pins come from another domain
    mps_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .async_i ({lowpower_request_pin, module_select_pin}),
        .sync_o  ({lp_pin_s, module_select_pin_s})
    );

    assign lowpower_effective = ctrl_q.sw_lowpower_request
                                || (ctrl_q.hw_lowpower_permit && lp_pin_s);

    // ack one cycle after the request; writes and read side effects land on the ack edge
    assign req   = wb_cyc_i && wb_stb_i;
    assign wr_ev = req && wb_ack_o && wb_we_i;
    assign rd_ev = req && wb_ack_o && !wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_ff @(posedge clk) begin
        if (sys_rst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req && !wb_ack_o;
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (wb_adr_i)
            OFS_STATUS: begin
                rd_word[STAT_STATE_LSB +: 2]         = module_state_o;
                rd_word[STAT_LP_EFF_BIT]             = lowpower_effective;
                rd_word[STAT_LP_PIN_BIT]             = lp_pin_s;
                rd_word[STAT_MODULE_SELECT_PIN_BIT]             = module_select_pin_s;
                rd_word[STAT_LANE_LSB +: 2*LANES]    = lane_state_bits;
            end
            OFS_CTRL: begin
                rd_word[CTRL_SW_LP_BIT]     = ctrl_q.sw_lowpower_request;
                rd_word[CTRL_HW_PERMIT_BIT] = ctrl_q.hw_lowpower_permit;
            end
            OFS_DEINIT:     rd_word[7:0]        = ctrl_q.datapath_deinit_mask;
            OFS_TXDIS:      rd_word[7:0]        = ctrl_q.tx_output_disable_mask;
            OFS_SQUELCH:    rd_word[7:0]        = ctrl_q.tx_squelch_force_mask;
            OFS_FLAGS:      rd_word[FLAG_W-1:0] = flags_q;
            OFS_IRQ_MASK:   rd_word[FLAG_W-1:0] = irq_mask_q;
            OFS_ACTIVE_CFG: rd_word[7:0]        = active_cfg_q;
            OFS_STAGED_CFG: rd_word[7:0]        = staged_cfg_q;
            default:        rd_word             = 32'h0000_0000;
        endcase
    end

    // data is sampled on the request edge and held through the ack cycle
    always_ff @(posedge clk) begin
        if (sys_rst)
            wb_dat_o <= 32'h0000_0000;
        else if (req && !wb_ack_o && !wb_we_i)
            wb_dat_o <= rd_word;
    end

    // control registers: held at the power-on defaults until management init is over
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RST;
        end else if (module_state_o == mgmt_init_state) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_ev) begin
            case (wb_adr_i)
                OFS_CTRL: begin
                    if (wb_sel_i[0]) begin
                        ctrl_q.sw_lowpower_request <= wb_dat_i[CTRL_SW_LP_BIT];
                        ctrl_q.hw_lowpower_permit  <= wb_dat_i[CTRL_HW_PERMIT_BIT];
                    end
                end
                OFS_DEINIT:
                    if (wb_sel_i[0]) ctrl_q.datapath_deinit_mask <= wb_dat_i[7:0];
                OFS_TXDIS:
                    if (wb_sel_i[0]) ctrl_q.tx_output_disable_mask <= wb_dat_i[7:0];
                OFS_SQUELCH:
                    if (wb_sel_i[0]) ctrl_q.tx_squelch_force_mask <= wb_dat_i[7:0];
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    // lane configuration sets: active is read-only to software
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            active_cfg_q <= DP_CFG_DEF;
            staged_cfg_q <= DP_CFG_DEF;
        end else if (module_state_o == mgmt_init_state) begin
            active_cfg_q <= DP_CFG_DEF;
            staged_cfg_q <= DP_CFG_DEF;
        end else if (wr_ev && wb_adr_i == OFS_STAGED_CFG && wb_sel_i[0]) begin
            staged_cfg_q <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            irq_mask_q <= IRQ_MASK_RST;
        else if (wr_ev && wb_adr_i == OFS_IRQ_MASK)
            irq_mask_q <= (irq_mask_q & ~wmask[FLAG_W-1:0]) | (wb_dat_i[FLAG_W-1:0] & wmask[FLAG_W-1:0]);
    end

    // module state machine
    always_comb begin
        state_d = module_state_o;
        case (module_state_o)
            mgmt_init_state:
                if (timer_q == TIMER_W'(MGMT_CYCLES - 1))
                    state_d = low_power_state;
            low_power_state:
                if (!lowpower_effective)
                    state_d = power_up_state;
            power_up_state:
                if (lowpower_effective)
                    state_d = low_power_state;
                else if (timer_q == TIMER_W'(PWRUP_CYC - 1))
                    state_d = ready_state;
            ready_state:
                // a renewed low power request drops the module straight back
                if (lowpower_effective)
                    state_d = low_power_state;
            default: state_d = mgmt_init_state;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            module_state_o <= mgmt_init_state;
            timer_q        <= '0;
        end else begin
            module_state_o <= state_d;
            if (state_d != module_state_o)
                timer_q <= '0;
            else if (module_state_o == mgmt_init_state || module_state_o == power_up_state)
                timer_q <= timer_q + 1'b1;
        end
    end

    // entry into low power or ready raises the module flag
    assign mod_entry_pulse = (state_d != module_state_o)
                             && (state_d == low_power_state || state_d == ready_state);

    always_ff @(posedge clk) begin
        if (sys_rst)
            high_power_en_o <= 1'b0;
        else
            high_power_en_o <= (state_d == power_up_state) || (state_d == ready_state);
    end

    // lanes run only in ready state, so they stay deactivated before it
    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi++) begin : g_lane
            mps_dp_lane #(
                .INIT_CYCLES (DP_INIT_CYC)
            ) u_lane (
                .clk            (clk),
                .sys_rst        (sys_rst),
                .module_ready   (module_state_o == ready_state),
                .deinit_bit     (ctrl_q.datapath_deinit_mask[gi]),
                .tx_disable_bit (ctrl_q.tx_output_disable_mask[gi]),
                .state_o        (lane_state[gi]),
                .changed_o      (lane_changed[gi]),
                .tx_enable_o    (lane_tx_en[gi])
            );
            assign lane_state_bits[2*gi +: 2] = lane_state[gi];
        end
    endgenerate

    assign tx_enable_o = lane_tx_en;

    always_ff @(posedge clk) begin
        if (sys_rst)
            tx_squelch_o <= '1;
        else
            tx_squelch_o <= ctrl_q.tx_squelch_force_mask | ~lane_tx_en;
    end

    // sticky flags; a read clears only what it returned, so an event in the clear cycle survives
    assign flag_set = {lane_changed, mod_entry_pulse};
    assign rd_clear = (rd_ev && wb_adr_i == OFS_FLAGS) ? wb_dat_o[FLAG_W-1:0] : '0;

    always_ff @(posedge clk) begin
        if (sys_rst)
            flags_q <= '0;
        else
            flags_q <= (flags_q & ~rd_clear) | flag_set;
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            irq_o <= 1'b0;
        else
            irq_o <= |(((flags_q & ~rd_clear) | flag_set) & ~irq_mask_q);
    end

endmodule // mps_top
`default_nettype wire

// ---- tb/mps_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module mps_properties #(
    parameter int unsigned MGMT_CYCLES = mps_pkg::MGMT_INIT_CYCLES,
    parameter int unsigned PWRUP_CYC   = mps_pkg::PWRUP_CYCLES
) (
    // clock and reset
    input wire logic                          clk,
    input wire logic                          sys_rst,
    // wishbone
    input wire logic                          wb_cyc_i,
    input wire logic                          wb_stb_i,
    input wire logic                          wb_we_i,
    input wire logic [7:0]                    wb_adr_i,
    input wire logic [31:0]                   wb_dat_o,
    input wire logic                          wb_ack_o,
    // module outputs
    input wire logic                          irq_o,
    input wire mps_pkg::mps_mod_state_t       module_state_o,
    input wire logic                          high_power_en_o,
    input wire logic [mps_pkg::LANES-1:0]     tx_enable_o
);
    import mps_pkg::*;

    mps_mod_state_t st_q;
    logic [15:0]    dwell_q;

    // run length of the state seen one sample ago, so a dwell can be judged at the exit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q    <= mgmt_init_state;
            dwell_q <= 16'h0;
        end else begin
            st_q    <= module_state_o;
            dwell_q <= (module_state_o != st_q) ? 16'h1 : dwell_q + 16'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_left_mgmt;
        st_q == mgmt_init_state && module_state_o != mgmt_init_state;
    endsequence
    sequence s_reached_ready;
        st_q == power_up_state && module_state_o == ready_state;
    endsequence
    sequence s_flags_read;
        wb_ack_o && !wb_we_i && wb_adr_i == OFS_FLAGS && module_state_o == low_power_state;
    endsequence

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_req_answered: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > OFS_STAGED_CFG |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_mgmt_dwell: assert property (s_left_mgmt |-> module_state_o == low_power_state &&
        dwell_q >= MGMT_CYCLES - 1 && dwell_q <= MGMT_CYCLES + 1)
        else $error("management init exit wrong");
    a_lowpower_irq: assert property (s_left_mgmt |-> ##[0:3] irq_o)
        else $error("no interrupt on low power entry");
    a_pwrup_dwell: assert property (s_reached_ready |-> dwell_q >= PWRUP_CYC && dwell_q <= PWRUP_CYC + 1)
        else $error("power up dwell wrong");
    a_ready_irq: assert property (s_reached_ready |-> ##[0:3] irq_o)
        else $error("no interrupt on ready entry");
    a_hp_state: assert property (high_power_en_o == (module_state_o inside {power_up_state, ready_state}))
        else $error("high power enable does not follow state");
    a_pwrup_dark: assert property (module_state_o == power_up_state && st_q == power_up_state |->
        tx_enable_o == '0)
        else $error("lane enabled during power up");
    a_read_drops_irq: assert property (s_flags_read |-> ##[1:3] !irq_o)
        else $error("interrupt kept after flag read");
endmodule // mps_properties
`default_nettype wire

// ---- tb/mps_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// host side of the module pins; the low power request pin moves on the host clock like a host gpio, module select stays high
module mps_host_model (
    // clock
    input  wire logic clk,
    // pin intent from the bench
    input  wire logic lp_hold,
    // module pins
    output logic      lowpower_request_pin,
    output logic      module_select_pin
);
    initial begin
        lowpower_request_pin = 1'b1;
        module_select_pin    = 1'b1;
    end
    always @(posedge clk) begin
        lowpower_request_pin <= lp_hold;
    end
endmodule // mps_host_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mps_pkg::*;
    logic           clk = 1'b0;
    logic           sys_rst = 1'b1;
    logic           wb_cyc = 1'b0;
    logic           wb_stb = 1'b0;
    logic           wb_we = 1'b0;
    logic [3:0]     wb_sel = 4'h0;
    logic [7:0]     wb_adr = 8'h00;
    logic [31:0]    wb_dat_w = 32'h0;
    logic [31:0]    wb_dat_r;
    logic           wb_ack;
    logic           lp_hold = 1'b1;
    logic           lp_pin;
    logic           sel_pin;
    logic           irq;
    mps_mod_state_t module_state;
    logic           hp_en;
    logic [7:0]     tx_en;
    logic [7:0]     squelch;
    logic [31:0]    rdat;
    int             fail_count = 0;
    int             num_checks = 0;
    int             cycles = 0;

    always #10 clk = ~clk;

    mps_host_model mps_host_model_inst (.clk(clk), .lp_hold(lp_hold), .lowpower_request_pin(lp_pin),
        .module_select_pin(sel_pin));
    mps_top #(.MGMT_CYCLES(4), .PWRUP_CYC(6), .DP_INIT_CYC(3), .DP_CFG_DEF(8'h01)) mps_top_inst (
        .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
        .lowpower_request_pin(lp_pin), .module_select_pin(sel_pin), .irq_o(irq),
        .module_state_o(module_state), .high_power_en_o(hp_en), .tx_enable_o(tx_en), .tx_squelch_o(squelch));

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one classic cycle; ack and read data are taken at the same edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= w;
        wb_sel   <= 4'hf;
        wb_adr   <= a;
        wb_dat_w <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        if (wb_ack !== 1'b1) chk("ack", 32'h1, 32'h0);
        rdat = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        wb_sel <= 4'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rdat & m);
    endtask

    task automatic wait_irq(input logic lvl);
        for (int i = 0; i < 40 && irq !== lvl; i++) @(posedge clk);
        chk("irq", {31'h0, lvl}, {31'h0, irq});
    endtask

    task automatic wait_state(input mps_mod_state_t s);
        for (int i = 0; i < 40 && module_state !== s; i++) @(posedge clk);
        chk("state", {30'h0, s}, {30'h0, module_state});
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            final_report;
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        wr(OFS_DEINIT, 32'h55);
        wait_irq(1'b1);
        chk("state", {30'h0, low_power_state}, {30'h0, module_state});
        rd(OFS_CTRL, 32'hffffffff, 32'h2, "ctrl");
        rd(OFS_DEINIT, 32'hffffffff, 32'h0, "deinit");
        rd(OFS_TXDIS, 32'hffffffff, 32'h0, "txdis");
        rd(OFS_SQUELCH, 32'hffffffff, 32'h0, "squelch");
        rd(OFS_ACTIVE_CFG, 32'hffffffff, 32'h1, "active_cfg");
        rd(OFS_STAGED_CFG, 32'hffffffff, 32'h1, "staged_cfg");
        rd(OFS_STATUS, 32'hffff0003, 32'h1, "status");
        rd(OFS_FLAGS, 32'hffffffff, 32'h1, "flags");
        wait_irq(1'b0);
        rd(OFS_FLAGS, 32'hffffffff, 32'h0, "flags_clear");
        rd(8'h40, 32'hffffffff, 32'h0, "unmapped");
        wr(OFS_ACTIVE_CFG, 32'h7);
        rd(OFS_ACTIVE_CFG, 32'hffffffff, 32'h1, "active_ro");
        wr(OFS_STAGED_CFG, 32'h7);
        rd(OFS_STAGED_CFG, 32'hffffffff, 32'h7, "staged_rw");
        wr(OFS_DEINIT, 32'hff);
        wr(OFS_TXDIS, 32'hff);
        lp_hold <= 1'b0;
        wr(OFS_CTRL, 32'h3);
        rd(OFS_STATUS, 32'h1f, 32'h15, "status_sw");
        lp_hold <= 1'b1;
        wr(OFS_CTRL, 32'h1);
        rd(OFS_STATUS, 32'h1f, 32'h1d, "status_sw_pin");
        wr(OFS_CTRL, 32'h2);
        rd(OFS_STATUS, 32'h1f, 32'h1d, "status_permit_pin");
        wr(OFS_CTRL, 32'h0);
        wait_state(power_up_state);
        chk("high_power", 32'h1, {31'h0, hp_en});
        chk("tx_enable", 32'h0, {24'h0, tx_en});
        wait_state(ready_state);
        wait_irq(1'b1);
        rd(OFS_FLAGS, 32'hffffffff, 32'h1, "flags_ready");
        rd(OFS_STATUS, 32'hffff0003, 32'h3, "status_ready");
        repeat (20) @(posedge clk);
        rd(OFS_STATUS, 32'hffff0000, 32'h0, "lanes_held");
        wr(OFS_IRQ_MASK, 32'h1ff);
        wr(OFS_DEINIT, 32'h0);
        repeat (20) @(posedge clk);
        chk("irq_masked", 32'h0, {31'h0, irq});
        rd(OFS_STATUS, 32'hffff0000, 32'haaaa0000, "lanes_init");
        chk("tx_enable", 32'h0, {24'h0, tx_en});
        rd(OFS_FLAGS, 32'hffffffff, 32'h1fe, "lane_flags");
        wr(OFS_IRQ_MASK, 32'h0);
        wr(OFS_SQUELCH, 32'h0f);
        wr(OFS_TXDIS, 32'h0);
        wait_irq(1'b1);
        repeat (10) @(posedge clk);
        rd(OFS_STATUS, 32'hffff0000, 32'hffff0000, "lanes_active");
        chk("tx_enable", 32'hff, {24'h0, tx_en});
        chk("squelch", 32'h0f, {24'h0, squelch});
        rd(OFS_FLAGS, 32'hffffffff, 32'h1fe, "active_flags");
        final_report;
    end
endmodule // tb

bind mps_top mps_properties #(.MGMT_CYCLES(MGMT_CYCLES), .PWRUP_CYC(PWRUP_CYC)) mps_properties_inst (
    .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .module_state_o(module_state_o), .high_power_en_o(high_power_en_o), .tx_enable_o(tx_enable_o));
`default_nettype wire
